// ---- verilog/printer_escape_command_parser.sv ----
module printer_escape_command_parser
  import printer_cmd_pkg::*;
#(
  parameter int LINE_DOTS = LINE_DOTS_DEF,
  parameter int TICK_CYCLES = DRAWER_TICK_CYCLES
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_parallel_variant,
  input wire logic [3:0] i_switch_charset,
  input wire logic i_config_switch_bit_five,
  input wire logic i_buffer_empty,
  input wire logic i_hw_flow,
  input wire logic i_dsr_space,
  input wire logic i_paper_near_end,
  input wire logic i_paper_end,
  input wire logic i_drawer_sense,
  output settings_t o_settings,
  output logic [POS_W-1:0] o_print_pos,
  output logic o_text_valid,
  output logic [7:0] o_text_data,
  output logic o_feed_valid,
  output logic [7:0] o_feed_lines,
  output logic o_clear_buffer,
  output logic o_bar_start,
  output logic [2:0] o_bar_type,
  output logic o_bar_valid,
  output logic [7:0] o_bar_data,
  output logic o_bar_end,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_paper_end_signal,
  output logic o_print_stop,
  output logic o_drawer_pin2,
  output logic o_drawer_pin5
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ESC, ST_GS, ST_SUB, ST_ARGS, ST_BAR_TYPE, ST_BAR_DATA, ST_BAR_SKIP
  } state_t;
  // ==========================================================
  // elaboration checks
  generate
    if (LINE_DOTS < 1 || LINE_DOTS > (1 << POS_W))
      $error("LINE_DOTS does not fit the position counter");
    if (TICK_CYCLES < 2)
      $error("TICK_CYCLES too small");
  endgenerate
  state_t state_reg;
  logic [7:0] cmd_reg;
  logic [7:0] sub_reg;
  logic [7:0] arg0_reg;
  logic [7:0] arg1_reg;
  logic gs_reg;
  logic [1:0] idx_reg;
  logic [1:0] need_reg;
  settings_t settings_reg;
  settings_t init_set;
  logic [POS_W-1:0] pos_reg;
  logic tx_pend_reg;
  logic [7:0] tx_byte_reg;
  logic drw_start_reg;
  drawer_cmd_t drw_cmd_reg;
  logic drw_busy;
  logic [7:0] b;
  logic done;
  logic esc_done;
  logic gs_done;
  logic init_now;
  logic line_start;
  logic sel_ok;
  logic bar_print;
  logic bar_stop;
  logic [15:0] abs_val;
  logic [15:0] rel_off;
  logic signed [16:0] rel_sum;
  logic abs_ok;
  logic rel_ok;
  // ==========================================================
  // argument counts per command
  function automatic logic [1:0] need_of(input logic gs, input logic [7:0] c);
    logic [1:0] n;
    n = 2'd0;
    if (gs)
    begin
      if (c == CMD_BAR_WIDTH || c == CMD_BAR_HEIGHT || c == CMD_BAR_TEXT)
        n = 2'd1;
    end
    else
    begin
      case (c)
        CMD_CHARSET, CMD_FEED_LINES, CMD_CODE_PAGE, CMD_PERIPH: n = 2'd1;
        CMD_UPSIDE, CMD_ROTATE: n = 2'd1;
        CMD_ABS_POS, CMD_REL_POS: n = 2'd2;
        CMD_PULSE: n = 2'd3;
        default: n = 2'd0;
      endcase
    end
    return n;
  endfunction : need_of
  // ==========================================================
  // decode of the byte now taken
  assign b = i_rx_data;
  assign done = (state_reg == ST_ARGS) && i_rx_valid && (idx_reg == need_reg - 2'd1);
  assign esc_done = done && !gs_reg;
  assign gs_done = done && gs_reg;
  assign init_now = (state_reg == ST_ESC) && i_rx_valid && (b == CMD_INIT);
  // line start: nothing buffered and position back at zero
  assign line_start = (pos_reg == '0) && i_buffer_empty;
  assign sel_ok = (arg0_reg == PIN_SEL_LO) || (arg0_reg == PIN_SEL_HI)
    || (arg0_reg == PIN_SEL_ASC_LO) || (arg0_reg == PIN_SEL_ASC_HI);
  assign bar_print = (state_reg == ST_BAR_DATA) && i_rx_valid
    && (b >= PRINT_MIN) && (b <= PRINT_MAX);
  assign bar_stop = (state_reg == ST_BAR_DATA) && i_rx_valid && !bar_print;
  assign abs_val = {b, arg0_reg};
  assign rel_off = {b, arg0_reg};
  assign rel_sum = $signed({1'b0, 16'(pos_reg)}) + $signed({rel_off[15], rel_off});
  assign abs_ok = abs_val < 16'(LINE_DOTS);
  assign rel_ok = !rel_sum[16] && (rel_sum[15:0] < 16'(LINE_DOTS));
  // ==========================================================
  // initial settings, switches reread on every init
  always_comb
  begin
    init_set = '0;
    init_set.charset = i_switch_charset;
    if (i_switch_charset > CHARSET_MAX[3:0] || i_switch_charset == CHARSET_CMD_A
        || i_switch_charset == CHARSET_CMD_B || i_switch_charset == CHARSET_CMD_C)
      init_set.charset = CHARSET_FALLBACK;
    init_set.near_end_stop = i_config_switch_bit_five;
    init_set.bar_width = BAR_WIDTH_INIT;
    init_set.bar_height = BAR_HEIGHT_INIT;
  end
  // ==========================================================
  // parser sequencing
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state_reg <= ST_IDLE;
      cmd_reg <= '0;
      sub_reg <= '0;
      arg0_reg <= '0;
      arg1_reg <= '0;
      gs_reg <= 1'b0;
      idx_reg <= '0;
      need_reg <= '0;
    end
    else if (i_rx_valid)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (b == BYTE_ESC)
            state_reg <= ST_ESC;
          else if (b == BYTE_GS)
            state_reg <= ST_GS;
        end
        ST_ESC, ST_GS:
        begin
          cmd_reg <= b;
          gs_reg <= (state_reg == ST_GS);
          idx_reg <= '0;
          need_reg <= need_of(state_reg == ST_GS, b);
          if (state_reg == ST_GS && b == CMD_BAR_PRINT)
            state_reg <= ST_BAR_TYPE;
          else if (state_reg == ST_ESC && b == CMD_SENSOR)
            state_reg <= ST_SUB;
          else if (need_of(state_reg == ST_GS, b) != 2'd0)
            state_reg <= ST_ARGS;
          else
            state_reg <= ST_IDLE;
        end
        ST_SUB:
        begin
          sub_reg <= b;
          need_reg <= 2'd1;
          if (b == SUB_NEAR_OUT || b == SUB_NEAR_STOP || b == SUB_FEED_SW)
            state_reg <= ST_ARGS;
          else
            state_reg <= ST_IDLE;
        end
        ST_ARGS:
        begin
          if (idx_reg == 2'd0)
            arg0_reg <= b;
          if (idx_reg == 2'd1)
            arg1_reg <= b;
          idx_reg <= idx_reg + 2'd1;
          if (done)
            state_reg <= ST_IDLE;
        end
        ST_BAR_TYPE:
        begin
          if (b <= BAR_TYPE_MAX && i_buffer_empty)
            state_reg <= ST_BAR_DATA;
          else
            state_reg <= ST_BAR_SKIP;
        end
        ST_BAR_DATA:
        begin
          if (bar_stop)
            state_reg <= ST_IDLE;
        end
        ST_BAR_SKIP:
        begin
          if (b == BYTE_NUL)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // settings
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || init_now)
      settings_reg <= init_set;
    else if (esc_done)
    begin
      case (cmd_reg)
        CMD_CHARSET:
          if (b <= CHARSET_MAX)
            settings_reg.charset <= b[3:0];
        CMD_SENSOR:
        begin
          if (sub_reg == SUB_NEAR_OUT && i_parallel_variant)
            settings_reg.near_end_output <= b[0];
          if (sub_reg == SUB_NEAR_STOP)
            settings_reg.near_end_stop <= b[0];
          if (sub_reg == SUB_FEED_SW)
            settings_reg.feed_sw_disable <= b[0];
        end
        CMD_CODE_PAGE:
          if (b <= ONE_BIT_MAX)
            settings_reg.code_page <= b[0];
        CMD_UPSIDE:
          if (line_start)
            settings_reg.upside_down <= b[0];
        CMD_ROTATE:
          if (b <= ONE_BIT_MAX)
            settings_reg.rotate_90 <= b[0];
        default: ;
      endcase
    end
    else if (gs_done)
    begin
      case (cmd_reg)
        CMD_BAR_WIDTH:
          if (b >= BAR_WIDTH_MIN && b <= BAR_WIDTH_MAX)
            settings_reg.bar_width <= b[2:0];
        CMD_BAR_HEIGHT:
          if (b >= BAR_HEIGHT_MIN)
            settings_reg.bar_height <= b;
        CMD_BAR_TEXT:
          if (b <= HRI_MAX)
            settings_reg.human_readable_text <= b[1:0];
        default: ;
      endcase
    end
  end
  // ==========================================================
  // print position
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || init_now)
      pos_reg <= '0;
    else if (esc_done && cmd_reg == CMD_FEED_LINES)
      pos_reg <= '0;
    else if (esc_done && cmd_reg == CMD_ABS_POS && abs_ok)
      pos_reg <= abs_val[POS_W-1:0];
    else if (esc_done && cmd_reg == CMD_REL_POS && rel_ok)
      pos_reg <= rel_sum[POS_W-1:0];
    else if (bar_stop)
      pos_reg <= '0;
  end
  // ==========================================================
  // data, feed and bar code events
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_text_valid <= 1'b0;
      o_text_data <= '0;
      o_feed_valid <= 1'b0;
      o_feed_lines <= '0;
      o_clear_buffer <= 1'b0;
      o_bar_start <= 1'b0;
      o_bar_type <= '0;
      o_bar_valid <= 1'b0;
      o_bar_data <= '0;
      o_bar_end <= 1'b0;
    end
    else
    begin
      // unprintable bytes other than NUL inside a bar code fall back to text
      o_text_valid <= i_rx_valid && (((state_reg == ST_IDLE) && b != BYTE_ESC
        && b != BYTE_GS) || (bar_stop && b != BYTE_NUL));
      o_text_data <= b;
      o_feed_valid <= esc_done && cmd_reg == CMD_FEED_LINES;
      o_feed_lines <= b;
      o_clear_buffer <= init_now;
      o_bar_start <= (state_reg == ST_BAR_TYPE) && i_rx_valid && b <= BAR_TYPE_MAX
        && i_buffer_empty;
      o_bar_type <= b[2:0];
      o_bar_valid <= bar_print;
      o_bar_data <= b;
      o_bar_end <= bar_stop;
    end
  end
  // ==========================================================
  // drawer pulse and paper sensor outputs
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      drw_start_reg <= 1'b0;
      drw_cmd_reg <= '0;
      o_paper_end_signal <= 1'b0;
      o_print_stop <= 1'b0;
    end
    else
    begin
      drw_start_reg <= esc_done && cmd_reg == CMD_PULSE && sel_ok && !drw_busy;
      drw_cmd_reg <= '{pin_select_bit: arg0_reg[0], on_units: arg1_reg, off_units: b};
      o_paper_end_signal <= i_paper_end
        || (settings_reg.near_end_output && i_paper_near_end);
      o_print_stop <= i_paper_end || (settings_reg.near_end_stop && i_paper_near_end);
    end
  end
  drawer_pulse #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_drawer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(drw_start_reg),
    .i_cmd(drw_cmd_reg),
    .o_pin2(o_drawer_pin2),
    .o_pin5(o_drawer_pin5),
    .o_busy(drw_busy)
  );
  // ==========================================================
  // status replies, serial variant only
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      tx_pend_reg <= 1'b0;
      tx_byte_reg <= '0;
      o_tx_valid <= 1'b0;
      o_tx_data <= '0;
    end
    else
    begin
      o_tx_valid <= 1'b0;
      if (tx_pend_reg && (!i_hw_flow || i_dsr_space))
      begin
        tx_pend_reg <= 1'b0;
        o_tx_valid <= 1'b1;
        o_tx_data <= tx_byte_reg;
      end
      else if (!tx_pend_reg && !i_parallel_variant && (state_reg == ST_ESC)
               && i_rx_valid && b == CMD_STATUS)
      begin
        tx_pend_reg <= 1'b1;
        tx_byte_reg <= '0;
        tx_byte_reg[STAT_NEAR_BIT] <= i_paper_near_end;
        tx_byte_reg[STAT_END_BIT] <= i_paper_end;
      end
      else if (!tx_pend_reg && !i_parallel_variant && esc_done
               && cmd_reg == CMD_PERIPH && b == PERIPH_ARG)
      begin
        tx_pend_reg <= 1'b1;
        tx_byte_reg <= '0;
        tx_byte_reg[0] <= i_drawer_sense;
      end
    end
  end
  assign o_settings = settings_reg;
  assign o_print_pos = pos_reg;
  // ==========================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_args_last(logic [7:0] c);
    esc_done && cmd_reg == c;
  endsequence
  property p_charset;
    s_args_last(CMD_CHARSET) and (b <= CHARSET_MAX)
      |=> settings_reg.charset == $past(b[3:0]);
  endproperty
  a_charset: assert property (p_charset) else $error("charset not taken");
  property p_reset_charset;
    $past(init_now) |-> settings_reg.charset != CHARSET_CMD_A
      && settings_reg.charset != CHARSET_CMD_B && settings_reg.charset != CHARSET_CMD_C;
  endproperty
  a_reset_charset: assert property (p_reset_charset) else $error("bad init charset");
  property p_feed_sw;
    s_args_last(CMD_SENSOR) and (sub_reg == SUB_FEED_SW)
      |=> settings_reg.feed_sw_disable == $past(b[0]);
  endproperty
  a_feed_sw: assert property (p_feed_sw) else $error("feed switch bit wrong");
  property p_feed;
    s_args_last(CMD_FEED_LINES) |=> o_feed_valid && o_feed_lines == $past(b) && pos_reg == '0;
  endproperty
  a_feed: assert property (p_feed) else $error("feed event wrong");
  property p_drawer_reject;
    s_args_last(CMD_PULSE) and !sel_ok |=> !drw_start_reg;
  endproperty
  a_drawer_reject: assert property (p_drawer_reject) else $error("bad selector pulsed");
  sequence s_status_req;
    state_reg == ST_ESC && i_rx_valid && b == CMD_STATUS && !i_parallel_variant && !tx_pend_reg;
  endsequence
  property p_status_sent;
    s_status_req ##1 (!i_hw_flow || i_dsr_space) |=> o_tx_valid && !o_tx_data[STAT_ZERO_BIT];
  endproperty
  a_status_sent: assert property (p_status_sent) else $error("status not sent");
  property p_hold_for_dsr;
    tx_pend_reg && i_hw_flow && !i_dsr_space |=> !o_tx_valid && tx_pend_reg;
  endproperty
  a_hold_for_dsr: assert property (p_hold_for_dsr) else $error("sent without ready");
  property p_abs_pos;
    s_args_last(CMD_ABS_POS) and !abs_ok |=> pos_reg == $past(pos_reg);
  endproperty
  a_abs_pos: assert property (p_abs_pos) else $error("out of line move taken");
  property p_init;
    init_now |=> settings_reg.bar_height == BAR_HEIGHT_INIT
      && settings_reg.bar_width == BAR_WIDTH_INIT && o_clear_buffer && pos_reg == '0;
  endproperty
  a_init: assert property (p_init) else $error("init incomplete");
endmodule : printer_escape_command_parser

// ---- verilog/printer_cmd_pkg.sv ----
// ==========================================================
package printer_cmd_pkg;
  localparam logic [7:0] BYTE_ESC = 8'h1B;
  localparam logic [7:0] BYTE_GS = 8'h1D;
  localparam logic [7:0] BYTE_NUL = 8'h00;
  localparam logic [7:0] CMD_CHARSET = 8'h52;
  localparam logic [7:0] CMD_SENSOR = 8'h63;
  localparam logic [7:0] SUB_NEAR_OUT = 8'h33;
  localparam logic [7:0] SUB_NEAR_STOP = 8'h34;
  localparam logic [7:0] SUB_FEED_SW = 8'h35;
  localparam logic [7:0] CMD_FEED_LINES = 8'h64;
  localparam logic [7:0] CMD_PULSE = 8'h70;
  localparam logic [7:0] CMD_CODE_PAGE = 8'h74;
  localparam logic [7:0] CMD_PERIPH = 8'h75;
  localparam logic [7:0] CMD_STATUS = 8'h76;
  localparam logic [7:0] CMD_UPSIDE = 8'h7B;
  localparam logic [7:0] CMD_ROTATE = 8'h56;
  localparam logic [7:0] CMD_ABS_POS = 8'h24;
  localparam logic [7:0] CMD_REL_POS = 8'h5C;
  localparam logic [7:0] CMD_INIT = 8'h40;
  localparam logic [7:0] CMD_BAR_PRINT = 8'h6B;
  localparam logic [7:0] CMD_BAR_WIDTH = 8'h77;
  localparam logic [7:0] CMD_BAR_HEIGHT = 8'h68;
  localparam logic [7:0] CMD_BAR_TEXT = 8'h48;
  localparam logic [7:0] CHARSET_MAX = 8'h0A;
  localparam logic [3:0] CHARSET_CMD_A = 4'h7;
  localparam logic [3:0] CHARSET_CMD_B = 4'h9;
  localparam logic [3:0] CHARSET_CMD_C = 4'hA;
  localparam logic [3:0] CHARSET_FALLBACK = 4'h0;
  localparam logic [7:0] ONE_BIT_MAX = 8'h01;
  localparam logic [7:0] PERIPH_ARG = 8'h00;
  localparam logic [7:0] BAR_TYPE_MAX = 8'h07;
  localparam logic [7:0] BAR_WIDTH_MIN = 8'h02;
  localparam logic [7:0] BAR_WIDTH_MAX = 8'h04;
  localparam logic [7:0] BAR_HEIGHT_MIN = 8'h01;
  localparam logic [7:0] HRI_MAX = 8'h03;
  localparam logic [2:0] BAR_WIDTH_INIT = 3'h3;
  localparam logic [7:0] BAR_HEIGHT_INIT = 8'hA2;
  localparam logic [7:0] PRINT_MIN = 8'h20;
  localparam logic [7:0] PRINT_MAX = 8'h7E;
  localparam logic [7:0] PIN_SEL_LO = 8'h00;
  localparam logic [7:0] PIN_SEL_HI = 8'h01;
  localparam logic [7:0] PIN_SEL_ASC_LO = 8'h30;
  localparam logic [7:0] PIN_SEL_ASC_HI = 8'h31;
  localparam int STAT_NEAR_BIT = 0;
  localparam int STAT_END_BIT = 2;
  localparam int STAT_ZERO_BIT = 4;
  localparam int POS_W = 10;
  localparam int LINE_DOTS_DEF = 448;
  localparam int DRAWER_UNIT_US = 2;
  localparam int CLK_PERIOD_NS = 50;
  localparam int DRAWER_TICK_CYCLES = (DRAWER_UNIT_US * 1000 * 1000) / CLK_PERIOD_NS;
  typedef struct packed {
    logic [3:0] charset;
    logic code_page;
    logic near_end_output;
    logic near_end_stop;
    logic feed_sw_disable;
    logic upside_down;
    logic rotate_90;
    logic [2:0] bar_width;
    logic [7:0] bar_height;
    logic [1:0] human_readable_text;
  } settings_t;
  typedef struct packed {
    logic pin_select_bit;
    logic [7:0] on_units;
    logic [7:0] off_units;
  } drawer_cmd_t;
endpackage : printer_cmd_pkg

// ---- verilog/drawer_pulse.sv ----
module drawer_pulse
  import printer_cmd_pkg::*;
#(
  parameter int TICK_CYCLES = DRAWER_TICK_CYCLES
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire drawer_cmd_t i_cmd,
  output logic o_pin2,
  output logic o_pin5,
  output logic o_busy
);
  typedef enum logic [1:0] {DP_IDLE, DP_ON, DP_OFF} dp_state_t;
  dp_state_t dp_reg;
  logic [31:0] div_reg;
  logic [7:0] left_reg;
  logic [7:0] off_reg;
  logic sel_reg;
  logic tick;
  // ==========================================================
  // unit divider, restarted per pulse so each unit is whole
  assign tick = (div_reg == 32'(TICK_CYCLES - 1));
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || i_start || tick)
      div_reg <= '0;
    else
      div_reg <= div_reg + 32'h1;
  end
  // ==========================================================
  // on phase then off phase; new starts ignored while busy
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      dp_reg <= DP_IDLE;
      left_reg <= '0;
      off_reg <= '0;
      sel_reg <= 1'b0;
    end
    else if (i_start && dp_reg == DP_IDLE)
    begin
      sel_reg <= i_cmd.pin_select_bit;
      off_reg <= i_cmd.off_units;
      if (i_cmd.on_units != 8'h00)
      begin
        dp_reg <= DP_ON;
        left_reg <= i_cmd.on_units;
      end
      else if (i_cmd.off_units != 8'h00)
      begin
        dp_reg <= DP_OFF;
        left_reg <= i_cmd.off_units;
      end
    end
    else if (tick && dp_reg != DP_IDLE)
    begin
      if (left_reg != 8'h01)
        left_reg <= left_reg - 8'h01;
      else if (dp_reg == DP_ON && off_reg != 8'h00)
      begin
        dp_reg <= DP_OFF;
        left_reg <= off_reg;
      end
      else
        dp_reg <= DP_IDLE;
    end
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_pin2 <= 1'b0;
      o_pin5 <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      o_pin2 <= (dp_reg == DP_ON) && !sel_reg;
      o_pin5 <= (dp_reg == DP_ON) && sel_reg;
      o_busy <= (dp_reg != DP_IDLE);
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_on_ends_on_unit;
    $fell(dp_reg == DP_ON) |-> $past(tick && left_reg == 8'h01);
  endproperty
  a_on_ends_on_unit: assert property (p_on_ends_on_unit) else $error("on phase cut short");
endmodule : drawer_pulse

// ---- verification/host_model.sv ----
// ==========================================================
// host side: byte sender and ready line
module host_model
(
  input wire logic i_sys_clk,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic o_dsr_space
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'hA5;
    o_dsr_space = 1'b0;
  end
  // released data shows the inverse so a stale byte never looks valid
  task automatic send(input logic [7:0] b);
    @(posedge i_sys_clk);
    #1 o_rx_valid = 1'b1;
    o_rx_data = b;
    @(posedge i_sys_clk);
    #1 o_rx_valid = 1'b0;
    o_rx_data = ~b;
  endtask : send
  // on count kept below 64 so the off count fits a byte
  task automatic kick(input logic [7:0] sel, input logic [7:0] on_n);
    send(8'h1B);
    send(8'h70);
    send(sel);
    send(on_n);
    send(8'(on_n * 4));
  endtask : kick
  task automatic ready(input logic v);
    @(posedge i_sys_clk);
    #1 o_dsr_space = v;
  endtask : ready
endmodule : host_model

// ---- verification/printer_escape_command_parser_bench.sv ----
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end
module printer_escape_command_parser_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // stimulus table: byte count, bytes, settings expected after
  localparam logic [57:0] ROWS [13] = '{
    {3'd3, 32'h1B520A00, 23'h510E88}, {3'd3, 32'h1B520B00, 23'h510E88},
    {3'd3, 32'h1B740100, 23'h550E88}, {3'd4, 32'h1B633301, 23'h570E88},
    {3'd4, 32'h1B633400, 23'h560E88}, {3'd4, 32'h1B633503, 23'h568E88},
    {3'd3, 32'h1B560100, 23'h56AE88}, {3'd3, 32'h1B7B0100, 23'h56EE88},
    {3'd3, 32'h1D770400, 23'h56F288}, {3'd3, 32'h1D770500, 23'h56F288},
    {3'd3, 32'h1D680100, 23'h56F004}, {3'd3, 32'h1D480300, 23'h56F007},
    {3'd3, 32'h1D480400, 23'h56F007}};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic par = 1'b1;
  logic buf_empty = 1'b1;
  logic hw_flow = 1'b1;
  logic near_end = 1'b0;
  logic paper_end = 1'b0;
  logic drawer_sense = 1'b1;
  logic text_valid;
  logic [7:0] text_data;
  logic [2:0] bar_type, bar_kind;
  logic rx_valid, dsr_space, feed_valid, clear_buf, bar_start, bar_valid, bar_end;
  logic tx_valid, pe_sig, stop, pin2, pin5;
  logic [7:0] rx_data, tx_data, tx_last, feed_lines, bar_data;
  logic [22:0] settings;
  logic [9:0] pos;
  int miscompares = 0;
  int n_compared = 0;
  int n_bar = 0;
  int n_tx = 0;
  int hi2 = 0;
  int hi5 = 0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    n_bar <= n_bar + int'(bar_start);
    n_tx <= n_tx + int'(tx_valid);
    hi2 <= hi2 + int'(pin2);
    hi5 <= hi5 + int'(pin5);
    if (tx_valid)
      tx_last <= tx_data;
    if (bar_start)
      bar_kind <= bar_type;
  end
  host_model host (.i_sys_clk(sys_clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_dsr_space(dsr_space));
  printer_escape_command_parser #(.TICK_CYCLES(4)) dut (.i_sys_clk(sys_clk), .i_rst(rst),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_parallel_variant(par),
    .i_switch_charset(4'h9), .i_config_switch_bit_five(1'b1), .i_buffer_empty(buf_empty),
    .i_hw_flow(hw_flow), .i_dsr_space(dsr_space), .i_paper_near_end(near_end),
    .i_paper_end(paper_end), .i_drawer_sense(drawer_sense), .o_settings(settings),
    .o_print_pos(pos), .o_text_valid(text_valid), .o_text_data(text_data),
    .o_feed_valid(feed_valid), .o_feed_lines(feed_lines),
    .o_clear_buffer(clear_buf), .o_bar_start(bar_start), .o_bar_type(bar_type),
    .o_bar_valid(bar_valid), .o_bar_data(bar_data), .o_bar_end(bar_end),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_paper_end_signal(pe_sig),
    .o_print_stop(stop), .o_drawer_pin2(pin2), .o_drawer_pin5(pin5));
  task automatic cmd(input logic [2:0] n, input logic [31:0] b);
    for (int i = 0; i < n; i++)
      host.send(b[31 - 8 * i -: 8]);
  endtask : cmd
  task automatic conclude();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // a missing reply ends the run instead of hanging it
  task automatic wait_tx(input int k);
    for (int i = 0; i < 20 && n_tx < k; i++)
      @(posedge sys_clk);
    #1;
    if (n_tx < k)
    begin
      miscompares++;
      conclude();
    end
  endtask : wait_tx
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    `CHK("settings", 23'h010E88, settings)
    foreach (ROWS[i])
    begin
      cmd(ROWS[i][57:55], ROWS[i][54:23]);
      `CHK("settings", ROWS[i][22:0], settings)
    end
    near_end = 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK("pe_sig", 1'b1, pe_sig)
    `CHK("stop", 1'b0, stop)
    cmd(4, 32'h1B242001);
    `CHK("pos", 10'd288, pos)
    cmd(3, 32'h1B7B0000);
    `CHK("settings", 23'h56F007, settings)
    cmd(4, 32'h1B5CF0FF);
    `CHK("pos", 10'd272, pos)
    cmd(4, 32'h1B24C001);
    `CHK("pos", 10'd272, pos)
    cmd(3, 32'h1B640300);
    `CHK("feed", 9'h103, {feed_valid, feed_lines})
    `CHK("pos", 10'd0, pos)
    cmd(4, 32'h1B241000);
    cmd(4, 32'h1D6B0441);
    `CHK("bar", 9'h141, {bar_valid, bar_data})
    host.send(8'h00);
    `CHK("bar_end", 11'h400, {bar_end, pos})
    host.send(8'h42);
    `CHK("text", 9'h142, {text_valid, text_data})
    `CHK("bar_type", 3'h4, bar_kind)
    buf_empty = 1'b0;
    cmd(4, 32'h1D6B0441);
    host.send(8'h00);
    buf_empty = 1'b1;
    `CHK("n_bar", 1, n_bar)
    host.kick(8'h02, 8'd2);
    repeat (60) @(posedge sys_clk);
    host.kick(8'h31, 8'd2);
    repeat (60) @(posedge sys_clk);
    host.kick(8'h00, 8'd1);
    repeat (40) @(posedge sys_clk);
    `CHK("hi5", 8, hi5)
    `CHK("hi2", 4, hi2)
    cmd(2, 32'h1B400000);
    `CHK("clear", 1'b1, clear_buf)
    `CHK("settings", 23'h010E88, settings)
    par = 1'b0;
    cmd(2, 32'h1B760000);
    repeat (5) @(posedge sys_clk);
    `CHK("n_tx", 0, n_tx)
    host.ready(1'b1);
    wait_tx(1);
    `CHK("status", 8'h01, tx_last & 8'h15)
    hw_flow = 1'b0;
    host.ready(1'b0);
    cmd(3, 32'h1B750000);
    wait_tx(2);
    `CHK("drawer", 8'h01, tx_last & 8'h11)
    paper_end = 1'b1;
    cmd(2, 32'h1B760000);
    wait_tx(3);
    `CHK("status", 8'h05, tx_last & 8'h15)
    `CHK("stop", 1'b1, stop)
    drawer_sense = 1'b0;
    cmd(3, 32'h1B750000);
    wait_tx(4);
    `CHK("drawer", 8'h00, tx_last & 8'h11)
    conclude();
  end
endmodule : printer_escape_command_parser_bench
